// file: core/reference_trim_margin_slew.sv
// top: command registers, start delay and scaled reference target
`timescale 1ns/1ps
`include "reference_trim_defines.svh"

module reference_trim_margin_slew #(
  parameter int DAC_WIDTH = 12,
  parameter int NOMINAL_CODE = 2048,
  parameter logic [6:0] BUS_ADDRESS = 7'h24,
  parameter int START_DELAY_CYCLES = (`START_DELAY_NS * 1000 + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS,
  parameter int STEP_BASE_CYCLES = (`STEP_BASE_NS * 1000) / `CLOCK_PERIOD_PS
) (
  // clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // pmbus pins, asynchronous to clock
  input wire reference_trim_pkg::pmbus_in_t bus_pins,
  output logic sda_out,
  output logic sda_oe,
  // converter side
  output logic [DAC_WIDTH-1:0] reference_code,
  output logic ramp_busy,
  output logic [2:0] supply_undervoltage_threshold
);
  if (DAC_WIDTH < 8 || DAC_WIDTH > 16) begin : g_bad_width
    $error("DAC_WIDTH must lie in 8..16");
  end
  if (START_DELAY_CYCLES < 1 || START_DELAY_CYCLES > 65535) begin : g_bad_delay
    $error("START_DELAY_CYCLES must lie in 1..65535");
  end
  if (STEP_BASE_CYCLES < 1 || STEP_BASE_CYCLES * 8 > 65535) begin : g_bad_step
    $error("STEP_BASE_CYCLES times 8 must fit 16 bits");
  end
  if (64'(NOMINAL_CODE) * 64'h2FB0 >= (64'h2710 << DAC_WIDTH)) begin : g_bad_nominal
    $error("NOMINAL_CODE too large for the widest margin and trim");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus events
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  always_ff @(posedge clock) begin
    if (reset) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else if (clock_enable) begin
      scl_sync <= {scl_sync[1:0], bus_pins.scl};
      sda_sync <= {sda_sync[1:0], bus_pins.sda};
    end
  end

  assign scl_rise = scl_sync[1] && !scl_sync[2];
  assign scl_fall = !scl_sync[1] && scl_sync[2];
  assign start_seen = scl_sync[1] && scl_sync[2] && !sda_sync[1] && sda_sync[2];
  assign stop_seen = scl_sync[1] && scl_sync[2] && sda_sync[1] && !sda_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // byte-level slave: write byte and read byte
  reference_trim_pkg::bus_state_t state;
  logic [3:0] bit_count;
  logic [7:0] shift;
  logic [7:0] command;
  logic [7:0] tx;
  logic [7:0] read_value;
  logic write_strobe;
  logic [7:0] operation;
  logic [7:0] mode_config;
  logic [7:0] output_trim_register;
  reference_trim_pkg::margin_levels_t output_margin_register;

  function automatic logic mapped(input logic [7:0] code);
    mapped = code == `OFF_OPERATION || code == `OFF_MODE_CONFIG || code == `OFF_OUTPUT_TRIM ||
             code == `OFF_OUTPUT_MARGIN || code == `OFF_UNDERVOLTAGE;
  endfunction : mapped

  always_comb begin
    unique case (command)
      `OFF_OPERATION: read_value = operation;
      `OFF_MODE_CONFIG: read_value = mode_config;
      `OFF_OUTPUT_TRIM: read_value = output_trim_register;
      `OFF_OUTPUT_MARGIN: read_value = output_margin_register;
      `OFF_UNDERVOLTAGE: read_value = {5'h00, supply_undervoltage_threshold}; // [RULE14]
      default: read_value = 8'h00;
    endcase
  end

  // the acknowledge bit is driven from the falling clock that follows the eighth bit
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= reference_trim_pkg::st_idle;
      bit_count <= 4'h0;
      shift <= 8'h00;
      command <= 8'h00;
      tx <= 8'h00;
      sda_oe <= 1'b0;
    end else if (clock_enable) begin
      if (start_seen) begin
        state <= reference_trim_pkg::st_address;
        bit_count <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_seen) begin
        state <= reference_trim_pkg::st_idle;
        sda_oe <= 1'b0;
      end else if (scl_rise && state != reference_trim_pkg::st_idle) begin
        if (bit_count == 4'h8) begin
          bit_count <= 4'h0;
          if (state == reference_trim_pkg::st_read && sda_sync[1]) begin
            state <= reference_trim_pkg::st_ignore;
          end
        end else begin
          bit_count <= bit_count + 4'h1;
          shift <= {shift[6:0], sda_sync[1]};
        end
      end else if (scl_fall && state == reference_trim_pkg::st_read) begin
        sda_oe <= (bit_count == 4'h8) ? 1'b0 : !tx[3'h7 - bit_count[2:0]];
      end else if (scl_fall && bit_count != 4'h8) begin
        sda_oe <= 1'b0;
      end else if (scl_fall) begin
        unique case (state)
          reference_trim_pkg::st_address: begin
            if (shift[7:1] == BUS_ADDRESS) begin
              sda_oe <= 1'b1;
              tx <= read_value;
              state <= shift[0] ? reference_trim_pkg::st_read : reference_trim_pkg::st_command;
            end else begin
              state <= reference_trim_pkg::st_ignore;
            end
          end
          reference_trim_pkg::st_command: begin
            if (mapped(shift)) begin
              command <= shift;
              sda_oe <= 1'b1;
              state <= reference_trim_pkg::st_write;
            end else begin
              state <= reference_trim_pkg::st_ignore;
            end
          end
          reference_trim_pkg::st_write: sda_oe <= 1'b1;
          reference_trim_pkg::st_idle, reference_trim_pkg::st_read, reference_trim_pkg::st_ignore: sda_oe <= 1'b0;
        endcase
      end
    end
  end

  assign write_strobe = clock_enable && scl_fall && !start_seen && !stop_seen && bit_count == 4'h8 &&
                        state == reference_trim_pkg::st_write;

  always_ff @(posedge clock) begin
    sda_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clock) begin
    if (reset) begin
      operation <= `RESET_OPERATION;
      mode_config <= `RESET_MODE_CONFIG;
      output_trim_register <= `RESET_OUTPUT_TRIM;
      output_margin_register <= `RESET_OUTPUT_MARGIN; // [RULE10]
      supply_undervoltage_threshold <= `RESET_UNDERVOLTAGE;
    end else if (write_strobe) begin
      if (command == `OFF_OPERATION) operation <= shift; // [RULE5]
      if (command == `OFF_MODE_CONFIG) mode_config <= shift;
      if (command == `OFF_OUTPUT_TRIM) output_trim_register <= shift;
      if (command == `OFF_OUTPUT_MARGIN) output_margin_register <= shift;
      // code 100 is stored as written; the threshold decoder downstream treats it as undefined
      if (command == `OFF_UNDERVOLTAGE) supply_undervoltage_threshold <= shift[2:0]; // [RULE12] [RULE13] [RULE14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scaled target: nominal times trim factor times margin factor
  logic [1:0] margin_mode;
  logic margin_active;
  logic [1:0] ramp_step_select;
  logic [4:0] output_trim_code;
  logic [13:0] trim_factor;
  logic [10:0] margin_factor;
  logic [47:0] scaled;
  logic [DAC_WIDTH-1:0] next_target;

  function automatic logic signed [4:0] trim_steps(input logic [4:0] code);
    if (code[4:2] == 3'h7) trim_steps = 5'sh0C;
    else if (code[4:2] == 3'h0) trim_steps = -5'sh0C;
    else if (code[4]) trim_steps = 5'(code - 5'h10);
    else trim_steps = 5'(code - 5'h0F);
  endfunction : trim_steps

  // offsets in tenths of a percent
  function automatic logic [7:0] high_tenths(input logic [3:0] code);
    case (code)
      4'h0: high_tenths = 8'h00;
      4'h1: high_tenths = 8'h09;
      4'h2: high_tenths = 8'h12;
      4'h3: high_tenths = 8'h1C;
      4'h4: high_tenths = 8'h25;
      4'h5: high_tenths = 8'h2F;
      4'h6: high_tenths = 8'h39;
      4'h7: high_tenths = 8'h43;
      4'h8: high_tenths = 8'h4D;
      4'h9: high_tenths = 8'h58;
      4'hA: high_tenths = 8'h63;
      4'hB: high_tenths = 8'h6D;
      default: high_tenths = 8'h78;
    endcase
  endfunction : high_tenths

  function automatic logic [7:0] low_tenths(input logic [3:0] code);
    case (code)
      4'h0: low_tenths = 8'h00;
      4'h1: low_tenths = 8'h0B;
      4'h2: low_tenths = 8'h15;
      4'h3: low_tenths = 8'h20;
      4'h4: low_tenths = 8'h2A;
      4'h5: low_tenths = 8'h34;
      4'h6: low_tenths = 8'h3E;
      4'h7: low_tenths = 8'h47;
      4'h8: low_tenths = 8'h51;
      4'h9: low_tenths = 8'h5A;
      4'hA: low_tenths = 8'h63;
      4'hB: low_tenths = 8'h6B;
      default: low_tenths = 8'h74;
    endcase
  endfunction : low_tenths

  assign margin_mode = operation[`OP_MARGIN_MSB:`OP_MARGIN_LSB];
  assign margin_active = margin_mode == `OP_MARGIN_HIGH || margin_mode == `OP_MARGIN_LOW; // [RULE5]
  assign ramp_step_select = mode_config[`RAMP_SEL_MSB:`RAMP_SEL_LSB];
  assign output_trim_code = output_trim_register[4:0];

  always_comb begin
    trim_factor = 14'(int'(`TRIM_UNITY) + int'(trim_steps(output_trim_code)) * int'(`TRIM_STEP)); // [RULE15]
    if (margin_mode == `OP_MARGIN_HIGH) begin
      margin_factor = `MARGIN_UNITY + 11'(high_tenths(output_margin_register.high)); // [RULE7]
    end else if (margin_mode == `OP_MARGIN_LOW) begin
      margin_factor = `MARGIN_UNITY - 11'(low_tenths(output_margin_register.low)); // [RULE8]
    end else begin
      margin_factor = `MARGIN_UNITY;
    end
    // the product, not the sum, keeps large trim and margin combined exact
    scaled = (48'(NOMINAL_CODE) * 48'(trim_factor) * 48'(margin_factor)) / `SCALE_DIVISOR; // [RULE9]
    next_target = scaled[DAC_WIDTH-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // start delay, then hand the new target to the stepper
  logic start_event;
  logic [15:0] delay_count;
  logic [DAC_WIDTH-1:0] ramp_target;
  logic [15:0] interval;

  assign start_event = write_strobe && (command == `OFF_OUTPUT_TRIM || command == `OFF_OPERATION ||
                       (command == `OFF_OUTPUT_MARGIN && margin_active)); // [RULE4] [RULE6] [RULE11]
  assign interval = 16'(STEP_BASE_CYCLES) << ramp_step_select; // [RULE2] [RULE3]

  // a second write during the delay restarts it, so the newest setting always wins
  always_ff @(posedge clock) begin
    if (reset) begin
      delay_count <= 16'h0000;
      ramp_target <= DAC_WIDTH'(NOMINAL_CODE);
    end else if (clock_enable) begin
      if (start_event) begin
        delay_count <= 16'(START_DELAY_CYCLES); // [RULE4] [RULE6]
      end else if (delay_count != 16'h0000) begin
        delay_count <= delay_count - 16'h0001;
        if (delay_count == 16'h0001) begin
          ramp_target <= next_target; // [RULE10] [RULE11]
        end
      end
    end
  end

  reference_stepper #(
    .DAC_WIDTH(DAC_WIDTH),
    .RESET_LEVEL(NOMINAL_CODE)
  ) u_stepper (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .target(ramp_target),
    .interval(interval),
    .level(reference_code),
    .busy(ramp_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_trim_write_delay: assert property (write_strobe && command == `OFF_OUTPUT_TRIM |=> // [RULE4]
    delay_count == 16'(START_DELAY_CYCLES))
    else $error("trim write did not start the delay");
  a_margin_rewrite: assert property (write_strobe && command == `OFF_OUTPUT_MARGIN && margin_active |=> // [RULE11]
    delay_count == 16'(START_DELAY_CYCLES))
    else $error("margin write while margining did not restart the ramp");
  a_target_waits: assert property ($changed(ramp_target) |-> $past(delay_count) == 16'h0001) // [RULE6]
    else $error("target changed before the start delay ran out");
  a_product_scale: assert property (margin_mode == `OP_MARGIN_HIGH && output_trim_code[4:2] == 3'h7 && // [RULE9]
    output_margin_register.high[3:2] == 2'h3 |->
    next_target == DAC_WIDTH'((64'(NOMINAL_CODE) * 64'h2A94 * 64'h460) / 64'h989680))
    else $error("trim and margin not combined as a product");
  a_low_default: assert property (margin_mode == `OP_MARGIN_LOW && output_trim_code == 5'h10 && // [RULE8]
    output_margin_register.low == 4'h5 |->
    next_target == DAC_WIDTH'((64'(NOMINAL_CODE) * 64'h2710 * 64'h3B4) / 64'h989680))
    else $error("margin low code 0101 not at -5.2 percent");
  a_threshold_write: assert property (write_strobe && command == `OFF_UNDERVOLTAGE |=> // [RULE12]
    supply_undervoltage_threshold == $past(shift[2:0]))
    else $error("threshold not taken from bits 2:0");
  a_threshold_read: assert property (state == reference_trim_pkg::st_read && // [RULE14]
    command == `OFF_UNDERVOLTAGE |-> tx[7:3] == 5'h00)
    else $error("unsupported threshold bits read back nonzero");
  c_margin_high_entry: cover property (write_strobe && command == `OFF_OPERATION &&
    shift[`OP_MARGIN_MSB:`OP_MARGIN_LSB] == `OP_MARGIN_HIGH);
  c_read_back: cover property (state == reference_trim_pkg::st_read && scl_fall && bit_count == 4'h8);
  c_slow_ramp: cover property (ramp_busy && ramp_step_select == 2'h3);
endmodule : reference_trim_margin_slew

// file: core/reference_trim_defines.svh
// offsets, field positions, reset values and timing for the reference trim block
// Summary of operation
// (RULE1) a new trim value moves the reference gradually in dac steps, never in one jump
// (RULE2) ramp_step_select 00/01/10/11 gives one step per 4/8/16/32 us, default 00
// (RULE3) margin level changes ramp too, at the same ramp_step_select interval
// (RULE4) after an output_trim_register write, wait about 50 us before stepping
// (RULE5) margining is enabled only through operation; magnitude comes from the margin register
// (RULE6) operation margin high starts the ramp after the same 50 us start delay
// (RULE7) margin_high_level codes: 0000 +0%, 0001 +0.9%, about 1% steps, 11xx +12.0%
// (RULE8) margin_low_level codes: 0000 -0%, 0001 -1.1%, 1011 -10.7%, 11xx -11.6%
// (RULE9) trim and margin together scale by the product of both factors, not the sum
// (RULE10) margin high before any level write ramps to the default high level
// (RULE11) a margin write while margining is on ramps again to the new level
// (RULE12) threshold bits 2:0: 0xx 10.2 V, 101 4.25 V default, 110 6.0 V, 111 8.1 V
// (RULE13) the host never writes threshold code 100
// (RULE14) undervoltage register bits 7:3 are ignored on write
// (RULE15) output_trim_code scales by 0.75% per code, spanning plus and minus 9%
// (RULE16) one dac code per interval toward target, hold at target, restart on new target
`ifndef REFERENCE_TRIM_DEFINES_SVH
`define REFERENCE_TRIM_DEFINES_SVH

`define OFF_OPERATION 8'h01
`define OFF_MODE_CONFIG 8'hD2
`define OFF_OUTPUT_TRIM 8'hD4
`define OFF_OUTPUT_MARGIN 8'hD5
`define OFF_UNDERVOLTAGE 8'hD6

`define RESET_OPERATION 8'h80
`define RESET_MODE_CONFIG 8'h00
`define RESET_OUTPUT_TRIM 8'h10
`define RESET_OUTPUT_MARGIN 8'h45
`define RESET_UNDERVOLTAGE 3'h5

`define RAMP_SEL_MSB 3
`define RAMP_SEL_LSB 2
`define OP_MARGIN_MSB 5
`define OP_MARGIN_LSB 4
`define OP_MARGIN_LOW 2'h1
`define OP_MARGIN_HIGH 2'h2

`define TRIM_UNITY 14'h2710
`define TRIM_STEP 7'h4B
`define MARGIN_UNITY 11'h3E8
`define SCALE_DIVISOR 48'h989680

`define CLOCK_PERIOD_PS 5000
`define START_DELAY_NS 50000
`define STEP_BASE_NS 4000

`endif

// file: core/reference_trim_pkg.sv
// types shared by the reference trim and margin block
package reference_trim_pkg;
  typedef enum logic [2:0] {st_idle, st_address, st_command, st_write, st_read, st_ignore} bus_state_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } pmbus_in_t;
  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
  } margin_levels_t;
endpackage : reference_trim_pkg

// file: core/reference_stepper.sv
// dac stepper: one code per interval toward the target
`timescale 1ns/1ps

module reference_stepper #(
  parameter int DAC_WIDTH = 12,
  parameter int RESET_LEVEL = 2048
) (
  // clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // target and pacing
  input wire logic [DAC_WIDTH-1:0] target,
  input wire logic [15:0] interval,
  // reference out
  output logic [DAC_WIDTH-1:0] level,
  output logic busy
);
  logic [15:0] timer;
  logic [DAC_WIDTH-1:0] last_target;
  logic reload;
  logic step;

  assign reload = target != last_target;
  assign step = !reload && timer == 16'h0000 && level != target;

  always_ff @(posedge clock) begin
    if (reset) begin
      last_target <= DAC_WIDTH'(RESET_LEVEL);
    end else if (clock_enable) begin
      last_target <= target;
    end
  end

  // a new target restarts the interval so the first step never comes early
  always_ff @(posedge clock) begin
    if (reset) begin
      timer <= 16'h0000;
    end else if (clock_enable) begin
      if (reload || step) begin
        timer <= interval - 16'h0001; // [RULE2] [RULE16]
      end else if (timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      level <= DAC_WIDTH'(RESET_LEVEL);
      busy <= 1'b0;
    end else if (clock_enable) begin
      if (step) begin
        level <= (target > level) ? level + 1'b1 : level - 1'b1; // [RULE1] [RULE3] [RULE16]
      end
      busy <= level != target;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] gap;
  logic [15:0] load_interval;

  always_ff @(posedge clock) begin
    if (reset) begin
      gap <= 16'h0000;
      load_interval <= 16'h0001;
    end else if (clock_enable) begin
      gap <= (reload || step) ? 16'h0000 : gap + 16'h0001;
      if (reload || step) begin
        load_interval <= interval;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_single_code_step: assert property ($changed(level) |-> // [RULE16]
    (level == $past(level) + 1'b1) || (level == $past(level) - 1'b1))
    else $error("reference moved by more than one code");
  a_hold_at_target: assert property (clock_enable && level == target && !reload |=> level == $past(level)) // [RULE16]
    else $error("reference left its target");
  a_step_spacing: assert property (step |-> gap == load_interval - 16'h0001) // [RULE2]
    else $error("step taken off the configured interval");
  c_ramp_finished: cover property ($fell(busy));
endmodule : reference_stepper

// file: sim/pmbus_host_model.sv
// behavioural pmbus host issuing byte writes and byte reads
`timescale 1ns/1ps

module pmbus_host_model #(
  parameter logic [6:0] ADDRESS = 7'h24
) (
  // bus lines
  output logic scl,
  output logic host_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // data moves only while scl is low, so a data bit never looks like start or stop
  task automatic bit_out(input logic b);
    host_low = !b;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
    #16;
  endtask : bit_out
  task automatic bit_in(output logic b);
    host_low = 1'b0;
    #16 scl = 1'b1;
    #16 b = sda;
    #16 scl = 1'b0;
    #16;
  endtask : bit_in
  task automatic start_cond();
    host_low = 1'b0;
    #16 scl = 1'b1;
    #32 host_low = 1'b1;
    #32 scl = 1'b0;
    #16;
  endtask : start_cond
  task automatic stop_cond();
    host_low = 1'b1;
    #16 scl = 1'b1;
    #32 host_low = 1'b0;
    #32;
  endtask : stop_cond
  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_in(a);
    ack = !a;
  endtask : byte_out
  ////////////////////////////////////////////////////////////////////////////////
  // margining is only ever switched on through the operation command
  task automatic write_cmd(input logic [7:0] cmd, input logic [7:0] data, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    byte_out({ADDRESS, 1'b0}, a0);
    byte_out(cmd, a1);
    byte_out(data, a2);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask : write_cmd
  task automatic read_cmd(input logic [7:0] cmd, output logic [7:0] data);
    logic a;
    start_cond();
    byte_out({ADDRESS, 1'b0}, a);
    byte_out(cmd, a);
    start_cond();
    byte_out({ADDRESS, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      bit_in(data[i]);
    end
    bit_out(1'b1);
    stop_cond();
  endtask : read_cmd
endmodule : pmbus_host_model

// file: sim/test_reference_trim_margin_slew.sv
// self-checking bench for the reference trim, margin and slew block
`timescale 1ns/1ps

module test_reference_trim_margin_slew;
  // short delay and step base keep the run brief
  localparam int DELAY = 200;
  localparam int BASE = 4;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clock_enable = 1'b1;
  logic scl;
  logic host_low;
  logic sda_line;
  reference_trim_pkg::pmbus_in_t bus_pins;
  logic sda_out;
  logic sda_oe;
  logic [11:0] reference_code;
  logic ramp_busy;
  logic [2:0] supply_undervoltage_threshold;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int arm_cyc = 0;
  int last_cyc = 0;
  int step_cycles = BASE;
  bit first_step = 1'b0;
  logic [11:0] last_code = 12'h800;
  logic last_busy = 1'b0;
  logic [11:0] expect_q[$];
  logic [7:0] rd;
  logic ack;
  logic [2:0] codes[5] = '{3'h0, 3'h3, 3'h5, 3'h6, 3'h7};

  always #2.5 clock = !clock;
  always @(posedge clock) cyc <= cyc + 1;
  // open drain with pull-up: either side pulling low wins
  assign sda_line = !(sda_oe || host_low);
  assign bus_pins = {scl, sda_line};

  reference_trim_margin_slew #(.START_DELAY_CYCLES(DELAY), .STEP_BASE_CYCLES(BASE)) uut (
    .clock(clock), .reset(reset), .clock_enable(clock_enable), .bus_pins(bus_pins),
    .sda_out(sda_out), .sda_oe(sda_oe), .reference_code(reference_code), .ramp_busy(ramp_busy),
    .supply_undervoltage_threshold(supply_undervoltage_threshold));
  pmbus_host_model host (.scl(scl), .host_low(host_low), .sda(sda_line));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  // expected dac code: nominal times trim factor times margin factor, floored
  function automatic logic [11:0] calc(input int trimf, input int marf);
    longint p;
    p = longint'(2048) * trimf * marf;
    return 12'(p / longint'(10000000));
  endfunction : calc
  // issue a command that starts a ramp, then wait for the monitor to settle it
  task automatic ramp(input logic [7:0] cmd, input logic [7:0] data, input logic [11:0] want);
    expect_q.push_back(want);
    host.write_cmd(cmd, data, ack);
    arm_cyc = cyc;
    first_step = 1'b1;
    for (int i = 0; i < 20000 && expect_q.size() > 0; i++) begin
      @(negedge clock);
    end
    if (expect_q.size() > 0) begin
      n_mismatch++;
      $display("wrong value at %0t: ramp never settled", $time);
      expect_q.delete();
    end
  endtask : ramp
  ////////////////////////////////////////////////////////////////////////////////
  // sampled at the falling edge so every flop update has landed
  always @(negedge clock) begin
    if (!reset && reference_code !== last_code) begin
      check({15'h0, reference_code == last_code + 12'h1 || reference_code + 12'h1 == last_code}, 16'h1);
      if (first_step) begin
        check({15'h0, cyc - arm_cyc >= DELAY + step_cycles - 45 && cyc - arm_cyc <= DELAY + step_cycles}, 16'h1);
      end else begin
        check(16'(cyc - last_cyc), 16'(step_cycles));
      end
      first_step = 1'b0;
      last_cyc = cyc;
    end
    if (last_busy === 1'b1 && ramp_busy === 1'b0 && expect_q.size() > 0) begin
      check({4'h0, reference_code}, {4'h0, expect_q.pop_front()});
    end
    last_code = reference_code;
    last_busy = ramp_busy;
  end

  initial begin
    // about two and a half times the expected run, still well inside the cycle budget
    #400000;
    n_mismatch++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(56));
    repeat (5) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    check({4'h0, reference_code}, 16'h0800);
    check({13'h0, supply_undervoltage_threshold}, 16'h0005);
    check({15'h0, sda_out}, 16'h0000);
    host.read_cmd(8'hD5, rd);
    check({8'h0, rd}, 16'h0045);
    host.write_cmd(8'hD7, 8'h5A, ack);
    check({15'h0, ack}, 16'h0000);
    // code 100 is never sent by the host
    foreach (codes[i]) begin
      host.write_cmd(8'hD6, {5'($urandom), codes[i]}, ack);
      check({13'h0, supply_undervoltage_threshold}, {13'h0, codes[i]});
      host.read_cmd(8'hD6, rd);
      check({8'h0, rd}, {13'h0, codes[i]});
    end
    ramp(8'h01, 8'hA0, calc(10000, 1037));
    ramp(8'h01, 8'h80, calc(10000, 1000));
    ramp(8'hD4, 8'h1C, calc(10900, 1000));
    host.write_cmd(8'hD2, 8'h0C, ack);
    step_cycles = BASE << 3;
    host.write_cmd(8'hD5, 8'h10, ack);
    ramp(8'h01, 8'hA0, calc(10900, 1009));
    ramp(8'hD5, 8'hC0, calc(10900, 1120));
    host.write_cmd(8'hD2, 8'h04, ack);
    step_cycles = BASE << 1;
    host.write_cmd(8'hD5, 8'hCB, ack);
    ramp(8'h01, 8'h90, calc(10900, 893));
    host.write_cmd(8'hD2, 8'h08, ack);
    step_cycles = BASE << 2;
    ramp(8'hD5, 8'hC5, calc(10900, 948));
    ramp(8'hD4, 8'h10, calc(10000, 948));
    // a frozen block must neither answer the bus nor take the write
    @(negedge clock);
    clock_enable = 1'b0;
    host.write_cmd(8'hD4, 8'h1C, ack);
    check({15'h0, ack}, 16'h0000);
    @(negedge clock);
    clock_enable = 1'b1;
    host.read_cmd(8'hD4, rd);
    check({8'h0, rd}, 16'h0010);
    check({4'h0, reference_code}, {4'h0, calc(10000, 948)});
    repeat (10) @(negedge clock);
    complete_run();
  end
endmodule : test_reference_trim_margin_slew
